// ==== rtl/wec_counter.sv ====
// Wake-up event counter with two channels and a classic Wishbone slave
// ==========================================================
//
// Decided for this implementation: register access over Wishbone.
module wec_counter
   import wec_pkg::*;
#(
   parameter int MS_CYC = WEC_MS_CYC
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [WEC_NIN-1:0] i_port_input_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [WEC_ADR_W-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic o_irq
);
   // ==========================================================
   // Helpers
   function automatic logic hit(input logic [WEC_ADR_W-1:0] a, input logic [31:0] idx);
      hit = (a[WEC_ADR_W-1:2] == idx[WEC_ADR_W-3:0]);
   endfunction : hit

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   wec_state_t st_reg;
   wec_state_t st_next;
   logic acc;
   logic wr;
   logic tick;
   logic [1:0] clr;
   logic [1:0] ev;
   logic [1:0] raw;
   logic [1:0][WEC_NIN:0] act;
   logic [1:0][WEC_NIN:0] edg;
   logic [WEC_NIN:0] lvl;
   logic [15:0] w16;
   logic [15:0] rd16;

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      acc = i_wb_cyc & i_wb_stb;
      // Write lands on the edge where the master sees ack
      wr = acc & i_wb_we & st_reg.ack;
      tick = (st_reg.ms == WEC_MS_W'(MS_CYC - 1));
      st_next.ms = tick ? '0 : st_reg.ms + 1'b1;
      // Synchroniser; first stage feeds only the second
      st_next.s1 = i_port_input_n;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      if (st_reg.s2 == st_reg.s3) begin
         st_next.stab = st_reg.s3;
      end
      clr = '0;
      if (wr && hit(i_wb_adr, WEC_IDX_STAT) && i_wb_sel[0]) begin
         clr[1] = i_wb_dat[WEC_STAT_CLR_B];
         clr[0] = i_wb_dat[WEC_STAT_CLR_A];
      end
      lvl = {st_reg.key, st_reg.stab};
      for (int c = 0; c < 2; c++) begin
         // Active level per input, soft key as an extra input on top
         act[c] = {st_reg.key, st_reg.stab ^ st_reg.pol[c]};
         raw[c] = |(act[c] & {1'b1, st_reg.sel[c]});
         // Edges come from the pins themselves, so with deb zero a polarity write is not an event
         st_next.prev[c] = lvl;
         edg[c] = ({1'b0, st_reg.pol[c]} & st_reg.prev[c] & ~lvl) |
                  (~{1'b0, st_reg.pol[c]} & ~st_reg.prev[c] & lvl);
         // Combined level filter; any drop of the level restarts it
         if (!raw[c]) begin
            st_next.dcnt[c] = '0;
         end else if (tick && st_reg.dcnt[c] != st_reg.deb) begin
            st_next.dcnt[c] = st_reg.dcnt[c] + 1'b1;
         end
         st_next.dout[c] = raw[c] && (st_reg.dcnt[c] == st_reg.deb) && st_reg.deb != '0;
         if (st_reg.deb == '0) begin
            // Edges of all selected inputs merge into one event
            ev[c] = |(edg[c] & {1'b1, st_reg.sel[c]});
         end else begin
            ev[c] = st_next.dout[c] & ~st_reg.dout[c];
         end
         if (clr[c]) begin
            st_next.cnt[c] = '0;
         end else if (ev[c]) begin
            st_next.cnt[c] = st_reg.cnt[c] + 1'b1;
         end
      end
      // Pending flags: hardware set wins over software clear
      if (wr && hit(i_wb_adr, WEC_IDX_STAT) && i_wb_sel[0]) begin
         if (i_wb_dat[WEC_STAT_PEND_B]) begin
            st_next.pend[1] = 1'b0;
         end
         if (i_wb_dat[WEC_STAT_PEND_A]) begin
            st_next.pend[0] = 1'b0;
         end
      end
      for (int c = 0; c < 2; c++) begin
         if (st_reg.irq_en[c] && ev[c] && !clr[c] && st_reg.cnt[c] == st_reg.cmp) begin
            st_next.pend[c] = 1'b1;
         end
      end
      // Register writes
      if (wr && hit(i_wb_adr, WEC_IDX_CTRL)) begin
         w16 = merge({7'h00, st_reg.irq_en, st_reg.key, st_reg.deb}, i_wb_dat, i_wb_sel);
         st_next.irq_en = {w16[WEC_CTRL_EN_B], w16[WEC_CTRL_EN_A]};
         st_next.key = w16[WEC_CTRL_KEY];
         st_next.deb = w16[WEC_CTRL_DEB_LSB +: WEC_DEB_W];
      end else if (wr && hit(i_wb_adr, WEC_IDX_CMP)) begin
         w16 = merge({8'h00, st_reg.cmp}, i_wb_dat, i_wb_sel);
         st_next.cmp = w16[WEC_CW-1:0];
      end else if (wr && hit(i_wb_adr, WEC_IDX_SEL_A)) begin
         w16 = merge({4'h0, st_reg.sel[0]}, i_wb_dat, i_wb_sel);
         st_next.sel[0] = w16[WEC_NIN-1:0];
      end else if (wr && hit(i_wb_adr, WEC_IDX_SEL_B)) begin
         w16 = merge({4'h0, st_reg.sel[1]}, i_wb_dat, i_wb_sel);
         st_next.sel[1] = w16[WEC_NIN-1:0];
      end else if (wr && hit(i_wb_adr, WEC_IDX_POL_A)) begin
         w16 = merge({4'h0, st_reg.pol[0]}, i_wb_dat, i_wb_sel);
         st_next.pol[0] = w16[WEC_NIN-1:0];
      end else if (wr && hit(i_wb_adr, WEC_IDX_POL_B)) begin
         w16 = merge({4'h0, st_reg.pol[1]}, i_wb_dat, i_wb_sel);
         st_next.pol[1] = w16[WEC_NIN-1:0];
      end else if (wr && hit(i_wb_adr, WEC_IDX_MASK)) begin
         w16 = merge({14'h0000, st_reg.mask}, i_wb_dat, i_wb_sel);
         st_next.mask = w16[1:0];
      end else begin
         w16 = WEC_RST16;
      end
      // Read mux; unmapped addresses answer with zero
      if (hit(i_wb_adr, WEC_IDX_CTRL)) begin
         rd16 = {7'h00, st_reg.irq_en, st_reg.key, st_reg.deb};
      end else if (hit(i_wb_adr, WEC_IDX_CMP)) begin
         rd16 = {8'h00, st_reg.cmp};
      end else if (hit(i_wb_adr, WEC_IDX_STAT)) begin
         rd16 = {12'h000, 2'b00, st_reg.pend};
      end else if (hit(i_wb_adr, WEC_IDX_CNT)) begin
         rd16 = {st_reg.cnt[1], st_reg.cnt[0]};
      end else if (hit(i_wb_adr, WEC_IDX_SEL_A)) begin
         rd16 = {4'h0, st_reg.sel[0]};
      end else if (hit(i_wb_adr, WEC_IDX_SEL_B)) begin
         rd16 = {4'h0, st_reg.sel[1]};
      end else if (hit(i_wb_adr, WEC_IDX_POL_A)) begin
         rd16 = {4'h0, st_reg.pol[0]};
      end else if (hit(i_wb_adr, WEC_IDX_POL_B)) begin
         rd16 = {4'h0, st_reg.pol[1]};
      end else if (hit(i_wb_adr, WEC_IDX_MASK)) begin
         rd16 = {14'h0000, st_reg.mask};
      end else begin
         rd16 = WEC_RST16;
      end
      st_next.ack = acc & ~st_reg.ack;
      st_next.rdat = (acc & ~st_reg.ack & ~i_wb_we) ? {16'h0000, rd16} : 32'h0000_0000;
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_wb_ack = st_reg.ack;
   assign o_wb_dat = st_reg.rdat;
   // Pending flags double as the sticky status; mask gates the line
   assign o_irq = |(st_reg.pend & st_reg.mask);

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   logic wstat;
   assign wstat = wr && hit(i_wb_adr, WEC_IDX_STAT) && i_wb_sel[0];

   property p_clr_b;
      wstat && i_wb_dat[WEC_STAT_CLR_B] |=> st_reg.cnt[1] == '0;
   endproperty
   a_clr_b: assert property (p_clr_b) else $error("count B not cleared");

   property p_clr_a;
      wstat && i_wb_dat[WEC_STAT_CLR_A] |=> st_reg.cnt[0] == '0;
   endproperty
   a_clr_a: assert property (p_clr_a) else $error("count A not cleared");

   property p_stat_rd;
      o_wb_ack && !i_wb_we && hit(i_wb_adr, WEC_IDX_STAT) |-> o_wb_dat[3:2] == 2'b00;
   endproperty
   a_stat_rd: assert property (p_stat_rd) else $error("clear bits read nonzero");

   property p_pend_b;
      $rose(st_reg.pend[1]) |-> $past(st_reg.irq_en[1] && ev[1] && st_reg.cnt[1] == st_reg.cmp);
   endproperty
   a_pend_b: assert property (p_pend_b) else $error("pending B without cause");

   property p_pend_a;
      $rose(st_reg.pend[0]) |-> $past(st_reg.irq_en[0] && ev[0] && st_reg.cnt[0] == st_reg.cmp);
   endproperty
   a_pend_a: assert property (p_pend_a) else $error("pending A without cause");

   property p_fire;
      st_reg.irq_en[0] && ev[0] && !clr[0] && st_reg.cnt[0] == st_reg.cmp |=> st_reg.pend[0];
   endproperty
   a_fire: assert property (p_fire) else $error("compare hit missed");

   property p_hold;
      st_reg.pend[1] && !(wstat && i_wb_dat[WEC_STAT_PEND_B]) |=> st_reg.pend[1];
   endproperty
   a_hold: assert property (p_hold) else $error("pending B lost");

   property p_step;
      !clr[0] |=> st_reg.cnt[0] == $past(st_reg.cnt[0]) ||
                  st_reg.cnt[0] == $past(st_reg.cnt[0]) + 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("count A jumped");

   property p_deb;
      $rose(st_reg.dout[0]) |-> $past(st_reg.dcnt[0]) == st_reg.deb && st_reg.deb != '0;
   endproperty
   a_deb: assert property (p_deb) else $error("debounce too short");

   property p_hold_a;
      st_reg.pend[0] && !(wstat && i_wb_dat[WEC_STAT_PEND_A]) |=> st_reg.pend[0];
   endproperty
   a_hold_a: assert property (p_hold_a) else $error("pending A lost");

   property p_step_b;
      !clr[1] |=> st_reg.cnt[1] == $past(st_reg.cnt[1]) ||
                  st_reg.cnt[1] == $past(st_reg.cnt[1]) + 8'h01;
   endproperty
   a_step_b: assert property (p_step_b) else $error("count B jumped");

   property p_pend_clr_a;
      wstat && i_wb_dat[WEC_STAT_PEND_A] &&
      !(st_reg.irq_en[0] && ev[0] && !clr[0] && st_reg.cnt[0] == st_reg.cmp) |=> !st_reg.pend[0];
   endproperty
   a_pend_clr_a: assert property (p_pend_clr_a) else $error("pending A not cleared");

   property p_clr_nopend_b;
      clr[1] && !st_reg.pend[1] |=> !st_reg.pend[1];
   endproperty
   a_clr_nopend_b: assert property (p_clr_nopend_b) else $error("pending B set on clear");

   property p_fire_b;
      st_reg.irq_en[1] && ev[1] && !clr[1] && st_reg.cnt[1] == st_reg.cmp |=> st_reg.pend[1];
   endproperty
   a_fire_b: assert property (p_fire_b) else $error("compare hit B missed");

   property p_unsel_a;
      st_reg.deb == '0 && !clr[0] && !(|(edg[0] & {1'b1, st_reg.sel[0]})) |=>
         st_reg.cnt[0] == $past(st_reg.cnt[0]);
   endproperty
   a_unsel_a: assert property (p_unsel_a) else $error("count A moved without edge");

   property p_deb_ev;
      st_reg.deb != '0 && ev[0] |-> raw[0] && st_reg.dcnt[0] == st_reg.deb;
   endproperty
   a_deb_ev: assert property (p_deb_ev) else $error("event before filter time");

   property p_key;
      $rose(st_reg.key) && st_reg.deb == '0 && !clr[1] |=>
         st_reg.cnt[1] == $past(st_reg.cnt[1]) + 8'h01;
   endproperty
   a_key: assert property (p_key) else $error("soft key not counted");

   property p_cnt_rd;
      o_wb_ack && !i_wb_we && hit(i_wb_adr, WEC_IDX_CNT) |->
         o_wb_dat[15:0] == $past({st_reg.cnt[1], st_reg.cnt[0]});
   endproperty
   a_cnt_rd: assert property (p_cnt_rd) else $error("count read wrong");

   property p_ack_pulse;
      o_wb_ack |=> !o_wb_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

   property p_rd_zero;
      !o_wb_ack |-> o_wb_dat == 32'h0000_0000;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data outside ack");

   c_fire_a: cover property (st_reg.irq_en[0] ##1 $rose(st_reg.pend[0]));
   c_fire_b: cover property ($rose(st_reg.pend[1]));
   c_wrap: cover property (st_reg.cnt[0] == 8'hff ##1 st_reg.cnt[0] == 8'h00);
   c_irq: cover property ($rose(o_irq));
   c_deb_ev: cover property (st_reg.deb != '0 && ev[0]);
endmodule : wec_counter

// ==== rtl/wec_pkg.sv ====
// Package of constants and types for the wake-up event counter
package wec_pkg;
   // ==========================================================
   // Register indices (byte address = 4 * index, low bits decoded)
   localparam logic [31:0] WEC_IDX_CTRL = 32'h5000_0100;
   localparam logic [31:0] WEC_IDX_CMP = 32'h5000_0102;
   localparam logic [31:0] WEC_IDX_STAT = 32'h5000_0104;
   localparam logic [31:0] WEC_IDX_CNT = 32'h5000_0106;
   localparam logic [31:0] WEC_IDX_SEL_A = 32'h5000_0108;
   localparam logic [31:0] WEC_IDX_SEL_B = 32'h5000_010a;
   localparam logic [31:0] WEC_IDX_POL_A = 32'h5000_010c;
   localparam logic [31:0] WEC_IDX_POL_B = 32'h5000_010e;
   localparam logic [31:0] WEC_IDX_MASK = 32'h5000_0110;
   localparam int WEC_ADR_W = 10;
   // ==========================================================
   // Field positions
   localparam int WEC_CTRL_EN_B = 8;
   localparam int WEC_CTRL_EN_A = 7;
   localparam int WEC_CTRL_KEY = 6;
   localparam int WEC_CTRL_DEB_LSB = 0;
   localparam int WEC_DEB_W = 6;
   localparam int WEC_STAT_CLR_B = 3;
   localparam int WEC_STAT_CLR_A = 2;
   localparam int WEC_STAT_PEND_B = 1;
   localparam int WEC_STAT_PEND_A = 0;
   localparam int WEC_CNT_B_LSB = 8;
   localparam int WEC_CNT_A_LSB = 0;
   localparam int WEC_NIN = 12;
   localparam int WEC_CW = 8;
   // ==========================================================
   // Reset values and timing
   localparam logic [15:0] WEC_RST16 = 16'h0000;
   localparam int WEC_CLK_PERIOD_NS = 10;
   localparam int WEC_DEB_UNIT_NS = 1000000;
   localparam int WEC_MS_CYC = WEC_DEB_UNIT_NS / WEC_CLK_PERIOD_NS;
   localparam int WEC_MS_W = 17;
   // ==========================================================
   // Whole block state
   typedef struct packed {
      logic [1:0][WEC_NIN-1:0] sel;
      logic [1:0][WEC_NIN-1:0] pol;
      logic [1:0] irq_en;
      logic key;
      logic [WEC_DEB_W-1:0] deb;
      logic [WEC_CW-1:0] cmp;
      logic [1:0] mask;
      logic [1:0] pend;
      logic [1:0][WEC_CW-1:0] cnt;
      logic [WEC_NIN-1:0] s1;
      logic [WEC_NIN-1:0] s2;
      logic [WEC_NIN-1:0] s3;
      logic [WEC_NIN-1:0] stab;
      logic [1:0][WEC_NIN:0] prev;
      logic [1:0][WEC_DEB_W-1:0] dcnt;
      logic [1:0] dout;
      logic [WEC_MS_W-1:0] ms;
      logic ack;
      logic [31:0] rdat;
   } wec_state_t;
endpackage : wec_pkg

// ==== verif/wec_key_model.sv ====
// Behavioural model of the key and sensor pins on the port inputs
// ==========================================================
// Pin model
module wec_key_model
   import wec_pkg::*;
(
   input wire logic i_clk,
   input wire logic [WEC_NIN-1:0] i_level,
   input wire logic i_chatter,
   output logic [WEC_NIN-1:0] o_pins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [WEC_NIN-1:0] last_reg = '0;
   logic [WEC_NIN-1:0] diff_reg = '0;
   logic [2:0] bounce_reg = '0;
   logic [WEC_NIN-1:0] pins_reg = '0;
   assign o_pins = pins_reg;
   // A worn contact chatters: changed pins flip six times, so they settle on the new level
   always @(posedge i_clk) begin
      if (i_level != last_reg) begin
         last_reg <= i_level;
         diff_reg <= i_level ^ last_reg;
         bounce_reg <= i_chatter ? 3'h6 : 3'h0;
         pins_reg <= i_level;
      end else if (bounce_reg != 3'h0) begin
         bounce_reg <= bounce_reg - 3'h1;
         pins_reg <= pins_reg ^ diff_reg;
      end
   end
endmodule : wec_key_model

// ==== verif/wakeup_event_counter_tb.sv ====
// Self-checking testbench of the wake-up event counter
module wakeup_event_counter_tb
   import wec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CT = WEC_IDX_CTRL[7:0];
   localparam logic [7:0] ST = WEC_IDX_STAT[7:0];
   localparam logic [7:0] CN = WEC_IDX_CNT[7:0];
   logic i_clk = 0;
   logic i_srst = 1;
   logic cyc = 0, stb = 0, we = 0, chatter = 0;
   logic [9:0] adr = '0;
   logic [31:0] wdat = '0;
   logic [3:0] sel = '0;
   logic [31:0] rdat;
   logic ack, irq;
   logic [WEC_NIN-1:0] lv = '0, pins;
   logic [7:0] regs [10];
   int n_mismatch = 0, samples_checked = 0, cycles = 0;
   // ==========================================================
   // Design, pin model, clock and timeout
   wec_counter #(.MS_CYC(4)) u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_port_input_n(pins),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq));
   wec_key_model u_keys (.i_clk(i_clk), .i_level(lv), .i_chatter(chatter), .o_pins(pins));
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         results();
      end
   end
   // ==========================================================
   // Bus cycles and comparison
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d,
                     output logic [15:0] q);
      int n;
      n = 0;
      @(posedge i_clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      sel <= 4'h3;
      adr <= {idx, 2'b00};
      wdat <= {16'h0000, d};
      do begin
         @(posedge i_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         n_mismatch++;
         results();
      end
      q = rdat[15:0];
      if (!w) chk(rdat[31:16], 16'h0000);
      cyc <= 0;
      stb <= 0;
      sel <= 4'h0;
   endtask : wb
   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      logic [15:0] q;
      wb(1'b1, idx, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
      logic [15:0] q;
      wb(1'b0, idx, 16'h0000, q);
      chk(q, exp);
   endtask : rd
   task automatic setp(input logic [WEC_NIN-1:0] v, input int hold);
      @(posedge i_clk);
      lv <= v;
      repeat (hold) @(posedge i_clk);
   endtask : setp
   task automatic irqchk(input logic e);
      @(negedge i_clk);
      chk({15'h0000, irq}, {15'h0000, e});
   endtask : irqchk
   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   // ==========================================================
   // Scenarios
   initial begin
      regs = '{CT, WEC_IDX_CMP[7:0], ST, CN, WEC_IDX_SEL_A[7:0], WEC_IDX_SEL_B[7:0],
               WEC_IDX_POL_A[7:0], WEC_IDX_POL_B[7:0], WEC_IDX_MASK[7:0], 8'hff};
      repeat (12) @(posedge i_clk);
      i_srst <= 0;
      foreach (regs[i]) rd(regs[i], WEC_RST16);
      wr(WEC_IDX_SEL_A[7:0], 16'h0005);
      wr(WEC_IDX_SEL_B[7:0], 16'h0002);
      wr(WEC_IDX_POL_A[7:0], 16'h0004);
      wr(WEC_IDX_POL_B[7:0], 16'h0002);
      rd(WEC_IDX_SEL_A[7:0], 16'h0005);
      rd(WEC_IDX_POL_B[7:0], 16'h0002);
      // Counted: pin0 rise (A), pin1 fall (B), pin2 fall (A); pin3 is not selected
      setp(12'h001, 12);
      setp(12'h003, 12);
      setp(12'h001, 12);
      setp(12'h005, 12);
      setp(12'h001, 12);
      setp(12'h009, 12);
      rd(CN, 16'h0102);
      setp(12'h00c, 12);
      setp(12'h009, 12);
      rd(CN, 16'h0103);
      wr(WEC_IDX_CMP[7:0], 16'h0003);
      wr(WEC_IDX_MASK[7:0], 16'h0003);
      wr(CT, 16'h0180);
      setp(12'h008, 12);
      setp(12'h009, 12);
      rd(ST, 16'h0001);
      irqchk(1'b1);
      setp(12'h008, 12);
      setp(12'h009, 12);
      rd(ST, 16'h0001);
      wr(ST, 16'h0001);
      rd(ST, 16'h0000);
      irqchk(1'b0);
      wr(ST, 16'h0000);
      rd(CN, 16'h0105);
      wr(ST, 16'h0004);
      rd(CN, 16'h0100);
      wr(ST, 16'h0008);
      rd(CN, 16'h0000);
      // Compare zero fires on the first event; a held soft key counts once
      wr(WEC_IDX_CMP[7:0], 16'h0000);
      wr(CT, 16'h01c0);
      repeat (8) @(posedge i_clk);
      rd(CN, 16'h0101);
      rd(ST, 16'h0003);
      wr(CT, 16'h01c0);
      repeat (8) @(posedge i_clk);
      rd(CN, 16'h0101);
      wr(ST, 16'h0002);
      rd(ST, 16'h0001);
      wr(ST, 16'h0001);
      for (int k = 0; k < 255; k++) begin
         wr(CT, 16'h0180);
         repeat (3) @(posedge i_clk);
         wr(CT, 16'h01c0);
         repeat (3) @(posedge i_clk);
      end
      wr(CT, 16'h0180);
      repeat (8) @(posedge i_clk);
      rd(CN, 16'h0000);
      // Debounce of 2 ticks (4 cycles each with MS_CYC 4): a short glitch is dropped, a chattering press counts once
      wr(WEC_IDX_SEL_A[7:0], 16'h0001);
      wr(WEC_IDX_SEL_B[7:0], 16'h0000);
      setp(12'h008, 12);
      wr(ST, 16'h000c);
      wr(CT, 16'h0002);
      setp(12'h009, 2);
      setp(12'h008, 30);
      rd(CN, 16'h0000);
      chatter <= 1;
      setp(12'h009, 60);
      rd(CN, 16'h0001);
      results();
   end
endmodule : wakeup_event_counter_tb
